// File: logic/dpc_pkg.sv
// Package: register map, field layout, codes and carriers of the playback path control
package dpc_pkg;

  localparam logic [7:0] DPC_OFS_RSVD_RO_A = 8'h34;
  localparam logic [7:0] DPC_OFS_RSVD_RO_B = 8'h35;
  localparam logic [7:0] DPC_OFS_DIN_CTL   = 8'h36;
  localparam logic [7:0] DPC_OFS_RSVD_RW_LO = 8'h37;
  localparam logic [7:0] DPC_OFS_RSVD_RW_HI = 8'h3B;
  localparam logic [7:0] DPC_OFS_PRB_SEL   = 8'h3C;
  localparam logic [7:0] DPC_OFS_RSVD_RO_C = 8'h3D;
  localparam logic [7:0] DPC_OFS_RSVD_RO_D = 8'h3E;
  localparam logic [7:0] DPC_OFS_SETUP     = 8'h3F;
  localparam logic [7:0] DPC_OFS_VOL_CTL   = 8'h40;

  localparam logic [7:0] DPC_RST_DIN_CTL = 8'h02;
  localparam logic [7:0] DPC_RST_PRB_SEL = 8'h01;
  localparam logic [7:0] DPC_RST_SETUP   = 8'h14;
  localparam logic [7:0] DPC_RST_VOL_CTL = 8'h0C;
  localparam logic [7:0] DPC_RST_RSVD    = 8'h00;

  localparam int DPC_DIN_MODE_LSB = 1;
  localparam int DPC_PRB_LSB      = 0;
  localparam int DPC_PRB_W        = 5;
  localparam int DPC_LPWR_BIT     = 7;
  localparam int DPC_RPWR_BIT     = 6;
  localparam int DPC_LROUTE_LSB   = 4;
  localparam int DPC_RROUTE_LSB   = 2;
  localparam int DPC_STEP_LSB     = 0;
  localparam int DPC_LMUTE_BIT    = 3;
  localparam int DPC_RMUTE_BIT    = 2;
  localparam int DPC_COUPLE_LSB   = 0;

  localparam logic [1:0] DPC_DIN_OFF = 2'h0;
  localparam logic [1:0] DPC_DIN_ON  = 2'h1;
  localparam logic [1:0] DPC_DIN_GPI = 2'h2;

  localparam logic [4:0] DPC_PRB_FIRST = 5'h01;
  localparam logic [4:0] DPC_PRB_LAST  = 5'h19;

  localparam logic [1:0] DPC_ROUTE_OFF  = 2'h0;
  localparam logic [1:0] DPC_ROUTE_OWN  = 2'h1;
  localparam logic [1:0] DPC_ROUTE_SWAP = 2'h2;
  localparam logic [1:0] DPC_ROUTE_MIX  = 2'h3;

  localparam logic [1:0] DPC_STEP_ONE = 2'h0;
  localparam logic [1:0] DPC_STEP_TWO = 2'h1;
  localparam logic [1:0] DPC_STEP_OFF = 2'h2;

  localparam logic [1:0] DPC_COUPLE_R2L = 2'h1;
  localparam logic [1:0] DPC_COUPLE_L2R = 2'h2;

  localparam logic [7:0] DPC_VOL_MAX  = 8'h30;
  localparam logic [7:0] DPC_VOL_MIN  = 8'h81;
  localparam logic [7:0] DPC_VOL_RSVD = 8'h80;
  localparam logic [7:0] DPC_VOL_RST  = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dpc_reg_req_t;

endpackage

// File: logic/dpc_gain_ramp.sv
// Soft-stepped applied gain of one playback channel
`timescale 1ns/10ps
`default_nettype none
module dpc_gain_ramp
  import dpc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] target_i,
  input  wire logic       step_i,
  input  wire logic       bypass_i,
  output logic      [7:0] gain_o
);

  typedef struct packed {
    logic [7:0] gain;
  } dpc_ramp_state_t;

  dpc_ramp_state_t q;
  dpc_ramp_state_t d;

  always_comb begin
    d = q;
    if (bypass_i) begin
      d.gain = target_i;
    end else if (step_i && (q.gain != target_i)) begin
      // Both ends stay within -127..+48, so 8-bit stepping never wraps
      if ($signed(target_i) > $signed(q.gain)) begin
        d.gain = q.gain + 8'h01;
      end else begin
        d.gain = q.gain - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q.gain <= DPC_VOL_RST;
    end else begin
      q <= d;
    end
  end

  assign gain_o = q.gain;

endmodule
`default_nettype wire

// File: logic/dpc_route_mix.sv
// Source selection and mono averaging for one DAC channel
`timescale 1ns/10ps
`default_nettype none
module dpc_route_mix
  import dpc_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic [W-1:0] own_i,
  input  wire logic [W-1:0] other_i,
  input  wire logic [1:0]   route_i,
  input  wire logic         pwr_i,
  output logic      [W-1:0] data_o
);

  logic [W:0] sum;

  // One extra bit keeps the sum exact before halving
  assign sum = {own_i[W-1], own_i} + {other_i[W-1], other_i};

  always_comb begin
    data_o = '0;
    if (pwr_i) begin
      case (route_i)
        DPC_ROUTE_OWN:  data_o = own_i;
        DPC_ROUTE_SWAP: data_o = other_i;
        DPC_ROUTE_MIX:  data_o = sum[W:1];
        default:        data_o = '0;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: logic/dpc_path_regs.sv
// Playback path control registers with routing, muting and soft-stepped gain
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Serial input mode 00 powers the input buffer down and the reset mode 01 feeds audio and clocks.
// - Mode 10 makes the pin a general-purpose input, 11 is reserved, and bit 0 reads the buffer level.
// - The five-bit block select picks configuration 1 to 25, resets to 1, other codes are reserved.
// - Setup bit 7 powers the left DAC channel, cleared at reset.
// - Setup bit 6 powers the right DAC channel, cleared at reset.
// - Left routing gives off, left, right or the average, resetting to left.
// - Right routing gives off, right, left or the average, resetting to right.
// - Step field gives one step per sample, per two samples or no stepping, and 11 is never written.
// - Volume control bit 3 mutes the left channel and resets muted.
// - Volume control bit 2 mutes the right channel and resets muted.
// - Coupling 01 copies the right volume to the left, 10 the left to the right, else independent.
// - While the compressor is enabled the volumes stay independent whatever the coupling field says.
// - Volumes are two's complement half-decibel codes from +24 dB down to -63.5 dB.
module dpc_path_regs
  import dpc_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire dpc_reg_req_t reg_req_i,
  output logic      [7:0]   reg_rdata_o,
  input  wire logic         din_pin_i,
  output logic              din_buf_en_o,
  output logic              din_audio_en_o,
  output logic              din_gpi_o,
  output logic      [4:0]   prb_sel_o,
  input  wire logic [7:0]   vol_left_i,
  input  wire logic [7:0]   vol_right_i,
  input  wire logic         drc_left_en_i,
  input  wire logic         drc_right_en_i,
  input  wire logic         sample_tick_i,
  input  wire logic [W-1:0] left_data_i,
  input  wire logic [W-1:0] right_data_i,
  output logic              dac_left_pwr_o,
  output logic              dac_right_pwr_o,
  output logic      [W-1:0] dac_left_data_o,
  output logic      [W-1:0] dac_right_data_o,
  output logic              left_mute_o,
  output logic              right_mute_o,
  output logic      [7:0]   left_gain_o,
  output logic      [7:0]   right_gain_o
);

  typedef struct packed {
    logic [7:0]   din_ctl;
    logic [7:0]   prb;
    logic [7:0]   setup;
    logic [7:0]   vol_ctl;
    logic         half;
    logic [7:0]   rdata;
    logic         din_buf_en;
    logic         din_audio_en;
    logic         din_gpi;
    logic         l_pwr;
    logic         r_pwr;
    logic         l_mute;
    logic         r_mute;
    logic [W-1:0] l_data;
    logic [W-1:0] r_data;
  } dpc_state_t;

  localparam dpc_state_t DPC_STATE_RST = '{
    din_ctl:      DPC_RST_DIN_CTL,
    prb:          DPC_RST_PRB_SEL,
    setup:        DPC_RST_SETUP,
    vol_ctl:      DPC_RST_VOL_CTL,
    rdata:        DPC_RST_RSVD,
    din_buf_en:   1'b1,
    din_audio_en: 1'b1,
    l_mute:       DPC_RST_VOL_CTL[DPC_LMUTE_BIT],
    r_mute:       DPC_RST_VOL_CTL[DPC_RMUTE_BIT],
    default:      '0
  };

  dpc_state_t   q;
  dpc_state_t   d;
  logic [1:0]   din_mode_d;
  logic [1:0]   step_mode;
  logic [1:0]   couple;
  logic         drc_any;
  logic         step_pulse;
  logic         bypass;
  logic         din_level;
  logic [7:0]   tgt_l;
  logic [7:0]   tgt_r;
  logic [W-1:0] mix_l;
  logic [W-1:0] mix_r;

  // Reserved volume codes fold onto the nearest legal end of the scale
  function automatic logic [7:0] vol_clamp(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if ($signed(v) > $signed(DPC_VOL_MAX)) begin
      r = DPC_VOL_MAX;
    end else if (v == DPC_VOL_RSVD) begin
      r = DPC_VOL_MIN;
    end
    return r;
  endfunction

  assign step_mode = q.setup[DPC_STEP_LSB +: 2];
  assign couple    = q.vol_ctl[DPC_COUPLE_LSB +: 2];
  assign drc_any   = drc_left_en_i | drc_right_en_i;
  assign din_level = din_pin_i & q.din_buf_en;

  // Compressor wins over coupling so the two channels never track each other
  assign tgt_l = vol_clamp((!drc_any && couple == DPC_COUPLE_R2L) ? vol_right_i
                                                                   : vol_left_i);
  assign tgt_r = vol_clamp((!drc_any && couple == DPC_COUPLE_L2R) ? vol_left_i
                                                                   : vol_right_i);

  // Code 11 is treated as no stepping, the safest outcome of a forbidden write
  assign bypass     = (step_mode == DPC_STEP_OFF) || (step_mode == 2'h3);
  assign step_pulse = sample_tick_i && ((step_mode == DPC_STEP_ONE) ||
                      ((step_mode == DPC_STEP_TWO) && q.half));

  always_comb begin
    d = q;
    if (reg_req_i.wr) begin
      if (reg_req_i.addr == DPC_OFS_DIN_CTL) begin
        d.din_ctl = {reg_req_i.wdata[7:1], 1'b0};
      end else if (reg_req_i.addr == DPC_OFS_PRB_SEL) begin
        d.prb = reg_req_i.wdata;
      end else if (reg_req_i.addr == DPC_OFS_SETUP) begin
        d.setup = reg_req_i.wdata;
      end else if (reg_req_i.addr == DPC_OFS_VOL_CTL) begin
        d.vol_ctl = reg_req_i.wdata;
      end
    end
    if (reg_req_i.rd) begin
      if (reg_req_i.addr == DPC_OFS_DIN_CTL) begin
        d.rdata = {q.din_ctl[7:1], din_level};
      end else if (reg_req_i.addr == DPC_OFS_PRB_SEL) begin
        d.rdata = q.prb;
      end else if (reg_req_i.addr == DPC_OFS_SETUP) begin
        d.rdata = q.setup;
      end else if (reg_req_i.addr == DPC_OFS_VOL_CTL) begin
        d.rdata = q.vol_ctl;
      end else begin
        d.rdata = DPC_RST_RSVD;
      end
    end
    din_mode_d     = d.din_ctl[DPC_DIN_MODE_LSB +: 2];
    d.din_buf_en   = (din_mode_d == DPC_DIN_ON) || (din_mode_d == DPC_DIN_GPI);
    d.din_audio_en = (din_mode_d == DPC_DIN_ON);
    d.din_gpi      = (q.din_ctl[DPC_DIN_MODE_LSB +: 2] == DPC_DIN_GPI) && din_pin_i;
    d.l_pwr        = d.setup[DPC_LPWR_BIT];
    d.r_pwr        = d.setup[DPC_RPWR_BIT];
    d.l_mute       = d.vol_ctl[DPC_LMUTE_BIT];
    d.r_mute       = d.vol_ctl[DPC_RMUTE_BIT];
    d.l_data       = mix_l;
    d.r_data       = mix_r;
    if (step_mode != DPC_STEP_TWO) begin
      d.half = 1'b0;
    end else if (sample_tick_i) begin
      d.half = ~q.half;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= DPC_STATE_RST;
    end else begin
      q <= d;
    end
  end

  dpc_route_mix #(
    .W (W)
  ) u_mix_left (
    .own_i   (left_data_i),
    .other_i (right_data_i),
    .route_i (q.setup[DPC_LROUTE_LSB +: 2]),
    .pwr_i   (q.l_pwr),
    .data_o  (mix_l)
  );

  dpc_route_mix #(
    .W (W)
  ) u_mix_right (
    .own_i   (right_data_i),
    .other_i (left_data_i),
    .route_i (q.setup[DPC_RROUTE_LSB +: 2]),
    .pwr_i   (q.r_pwr),
    .data_o  (mix_r)
  );

  dpc_gain_ramp u_ramp_left (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .target_i (tgt_l),
    .step_i   (step_pulse),
    .bypass_i (bypass),
    .gain_o   (left_gain_o)
  );

  dpc_gain_ramp u_ramp_right (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .target_i (tgt_r),
    .step_i   (step_pulse),
    .bypass_i (bypass),
    .gain_o   (right_gain_o)
  );

  assign reg_rdata_o      = q.rdata;
  assign din_buf_en_o     = q.din_buf_en;
  assign din_audio_en_o   = q.din_audio_en;
  assign din_gpi_o        = q.din_gpi;
  assign prb_sel_o        = q.prb[DPC_PRB_LSB +: DPC_PRB_W];
  assign dac_left_pwr_o   = q.l_pwr;
  assign dac_right_pwr_o  = q.r_pwr;
  assign dac_left_data_o  = q.l_data;
  assign dac_right_data_o = q.r_data;
  assign left_mute_o      = q.l_mute;
  assign right_mute_o     = q.r_mute;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  AST_DIN_OFF: assert property (
    q.din_ctl[DPC_DIN_MODE_LSB +: 2] == DPC_DIN_OFF |-> !din_buf_en_o && !din_audio_en_o)
    else $error("input buffer active while disabled");

  AST_DIN_READ: assert property (
    reg_req_i.rd && !reg_req_i.wr && reg_req_i.addr == DPC_OFS_DIN_CTL
    |=> reg_rdata_o[0] == $past(din_pin_i && din_buf_en_o))
    else $error("input level bit wrong on readback");

  AST_PRB_WRITE: assert property (
    reg_req_i.wr && reg_req_i.addr == DPC_OFS_PRB_SEL
    |=> prb_sel_o == $past(reg_req_i.wdata[4:0]) ##1 $stable(prb_sel_o) || $past(reg_req_i.wr))
    else $error("block select not taken");

  AST_LEFT_PWR: assert property (
    reg_req_i.wr && reg_req_i.addr == DPC_OFS_SETUP
    |=> dac_left_pwr_o == $past(reg_req_i.wdata[7]))
    else $error("left power does not follow setup bit 7");

  AST_RIGHT_PWR: assert property (
    reg_req_i.wr && reg_req_i.addr == DPC_OFS_SETUP
    |=> dac_right_pwr_o == $past(reg_req_i.wdata[6]))
    else $error("right power does not follow setup bit 6");

  AST_LEFT_SWAP: assert property (
    q.setup[DPC_LROUTE_LSB +: 2] == DPC_ROUTE_SWAP && q.l_pwr
    |=> dac_left_data_o == $past(right_data_i))
    else $error("left channel not fed from right data");

  AST_RIGHT_OFF: assert property (
    q.setup[DPC_RROUTE_LSB +: 2] == DPC_ROUTE_OFF |=> dac_right_data_o == '0)
    else $error("right channel not silent when routed off");

  AST_STEP_OFF: assert property (
    step_mode == DPC_STEP_OFF |=> left_gain_o == $past(tgt_l))
    else $error("gain not applied at once with stepping off");

  AST_STEP_TWO: assert property (
    step_mode == DPC_STEP_TWO && sample_tick_i && !q.half |=> $stable(left_gain_o))
    else $error("gain moved on the skipped sample");

  AST_MUTE: assert property (
    reg_req_i.wr && reg_req_i.addr == DPC_OFS_VOL_CTL
    |=> left_mute_o == $past(reg_req_i.wdata[3]) && right_mute_o == $past(reg_req_i.wdata[2]))
    else $error("mute flags do not follow volume control write");

  AST_COUPLE: assert property (
    !drc_any && couple == DPC_COUPLE_R2L && bypass
    |=> left_gain_o == $past(vol_clamp(vol_right_i)))
    else $error("left gain not coupled to right volume");

  AST_DRC: assert property (
    drc_any && bypass |=> left_gain_o == $past(vol_clamp(vol_left_i))
                       && right_gain_o == $past(vol_clamp(vol_right_i)))
    else $error("coupling applied with compressor enabled");

  AST_VOL_RANGE: assert property (
    tgt_l != DPC_VOL_RSVD && $signed(tgt_l) <= $signed(DPC_VOL_MAX))
    else $error("reserved volume code reached the gain stage");

  AST_RAMP_STEP: assert property (
    step_pulse && !bypass && left_gain_o != tgt_l
    |=> left_gain_o == $past(left_gain_o) + 8'h01 || left_gain_o == $past(left_gain_o) - 8'h01)
    else $error("applied gain did not move by one code");

  // Further checks, second-channel ones among them, since left-only checks miss a crossed wire
  AST_DIN_ON: assert property (
    q.din_ctl[DPC_DIN_MODE_LSB +: 2] == DPC_DIN_ON |-> din_buf_en_o && din_audio_en_o)
    else $error("input pin not enabled in its reset mode");

  AST_DIN_GPI: assert property (
    q.din_ctl[DPC_DIN_MODE_LSB +: 2] == DPC_DIN_GPI |=> din_gpi_o == $past(din_pin_i))
    else $error("general-purpose input does not follow the pin");

  AST_PRB_READ: assert property (
    reg_req_i.rd && reg_req_i.addr == DPC_OFS_PRB_SEL
    |=> reg_rdata_o[4:0] == $past(prb_sel_o))
    else $error("block select readback differs from the selected block");

  AST_LEFT_DOWN: assert property (
    !dac_left_pwr_o |=> dac_left_data_o == '0)
    else $error("powered-down left channel carries data");

  AST_RIGHT_DOWN: assert property (
    !dac_right_pwr_o |=> dac_right_data_o == '0)
    else $error("powered-down right channel carries data");

  AST_LEFT_OWN: assert property (
    q.setup[DPC_LROUTE_LSB +: 2] == DPC_ROUTE_OWN && q.l_pwr
    |=> dac_left_data_o == $past(left_data_i))
    else $error("left channel not fed from left data");

  AST_RIGHT_SWAP: assert property (
    q.setup[DPC_RROUTE_LSB +: 2] == DPC_ROUTE_SWAP && q.r_pwr
    |=> dac_right_data_o == $past(left_data_i))
    else $error("right channel not fed from left data");

  AST_STEP_HOLD: assert property (
    step_mode == DPC_STEP_ONE && !sample_tick_i
    |=> $stable(left_gain_o) && $stable(right_gain_o))
    else $error("gain moved without a sample tick");

  AST_COUPLE_L2R: assert property (
    !drc_any && couple == DPC_COUPLE_L2R && bypass
    |=> right_gain_o == $past(vol_clamp(vol_left_i)))
    else $error("right gain not coupled to left volume");

  AST_RAMP_RIGHT: assert property (
    step_pulse && !bypass && right_gain_o != tgt_r
    |=> right_gain_o == $past(right_gain_o) + 8'h01
        || right_gain_o == $past(right_gain_o) - 8'h01)
    else $error("applied right gain did not move by one code");

  COV_MIX_LEFT: cover property (
    q.setup[DPC_LROUTE_LSB +: 2] == DPC_ROUTE_MIX && q.l_pwr ##1 dac_left_data_o != '0);
  COV_COUPLE: cover property (!drc_any && couple == DPC_COUPLE_R2L && vol_left_i != vol_right_i);
  COV_DRC_HOLD: cover property (drc_any && couple != 2'h0 && vol_left_i != vol_right_i);
  COV_RAMP_TWO: cover property (step_mode == DPC_STEP_TWO && step_pulse && left_gain_o != tgt_l);
  COV_GPI_READ: cover property (
    q.din_ctl[DPC_DIN_MODE_LSB +: 2] == DPC_DIN_GPI && reg_req_i.rd
    && reg_req_i.addr == DPC_OFS_DIN_CTL);

endmodule
`default_nettype wire

// File: tb/tb_dpc_path_regs.sv
// Self-checking testbench of the playback path control registers
`timescale 1ns/10ps
`default_nettype none
module tb_dpc_path_regs
  import dpc_pkg::*;
;
  logic         clk_i;
  logic         rst_b_i;
  dpc_reg_req_t req;
  logic [7:0]   rdata;
  logic         din_pin;
  logic         buf_en;
  logic         audio_en;
  logic         general_purpose_input;
  logic [4:0]   prb;
  logic [7:0]   vol_l;
  logic [7:0]   vol_r;
  logic         drc_l;
  logic         drc_r;
  logic         tick;
  logic [15:0]  ldat;
  logic [15:0]  rdat;
  logic         lpwr;
  logic         rpwr;
  logic [15:0]  lout;
  logic [15:0]  rout;
  logic         lmute;
  logic         rmute;
  logic [7:0]   lgain;
  logic [7:0]   rgain;
  int           fail_count;
  int           check_count;

  dpc_path_regs #(.W(16)) dpc_path_regs_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .din_pin_i(din_pin), .din_buf_en_o(buf_en), .din_audio_en_o(audio_en),
    .din_gpi_o(general_purpose_input), .prb_sel_o(prb), .vol_left_i(vol_l), .vol_right_i(vol_r),
    .drc_left_en_i(drc_l), .drc_right_en_i(drc_r), .sample_tick_i(tick),
    .left_data_i(ldat), .right_data_i(rdat), .dac_left_pwr_o(lpwr),
    .dac_right_pwr_o(rpwr), .dac_left_data_o(lout), .dac_right_data_o(rout),
    .left_mute_o(lmute), .right_mute_o(rmute), .left_gain_o(lgain),
    .right_gain_o(rgain)
  );

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic summarize;
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One edge after the strobe edge, so a second register stage is covered too
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req.wr <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req.rd <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    check(rdata, exp);
  endtask

  task automatic drive_vol(input logic [7:0] l, input logic [7:0] r);
    @(posedge clk_i);
    vol_l <= l;
    vol_r <= r;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_i);
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
    end
    @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic gains(input logic [7:0] l, input logic [7:0] r);
    check(lgain, l);
    check(rgain, r);
  endtask

  task automatic test_reset;
    repeat (5) @(negedge clk_i);
    check({buf_en, audio_en, general_purpose_input, prb}, 8'hC1);
    check({lpwr, rpwr, lmute, rmute}, 4'h3);
    check(lout | rout, 16'h0000);
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    reg_rd(DPC_OFS_DIN_CTL, 8'h02);
    reg_rd(DPC_OFS_PRB_SEL, 8'h01);
    reg_rd(DPC_OFS_SETUP, 8'h14);
    reg_rd(DPC_OFS_VOL_CTL, 8'h0C);
  endtask

  task automatic test_din;
    logic eb;
    @(posedge clk_i);
    din_pin <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      eb = (m == 1) || (m == 2);
      reg_wr(DPC_OFS_DIN_CTL, {5'h00, m[1:0], 1'b1});
      check({buf_en, audio_en, general_purpose_input}, {eb, m == 1, m == 2});
      reg_rd(DPC_OFS_DIN_CTL, {5'h00, m[1:0], eb});
    end
    reg_wr(DPC_OFS_DIN_CTL, 8'h04);
    @(posedge clk_i);
    din_pin <= 1'b0;
    repeat (2) @(negedge clk_i);
    check(general_purpose_input, 1'b0);
    reg_rd(DPC_OFS_DIN_CTL, 8'h04);
    reg_wr(DPC_OFS_DIN_CTL, 8'h02);
  endtask

  task automatic test_prb;
    logic [4:0] codes [3] = '{5'h01, 5'h0D, 5'h19};
    foreach (codes[i]) begin
      reg_wr(DPC_OFS_PRB_SEL, {3'h0, codes[i]});
      check(prb, codes[i]);
      reg_rd(DPC_OFS_PRB_SEL, {3'h0, codes[i]});
    end
  endtask

  // Refused addresses must neither store nor disturb a live register
  task automatic test_reserved;
    logic [7:0] adr [8] = '{8'h34, 8'h35, 8'h37, 8'h39, 8'h3B, 8'h3D, 8'h3E, 8'h41};
    foreach (adr[i]) begin
      // Only the read-only reserved address 0x35 and the unmapped 0x41 get a write
      if (adr[i] == DPC_OFS_RSVD_RO_B || adr[i] == 8'h41) begin
        reg_wr(adr[i], 8'hFF);
      end
      reg_rd(adr[i], 8'h00);
    end
    reg_rd(DPC_OFS_PRB_SEL, 8'h19);
  endtask

  task automatic test_route;
    logic [15:0] el [4] = '{16'h0000, 16'h8001, 16'h0002, 16'hC001};
    logic [15:0] er [4] = '{16'h0000, 16'h0002, 16'h8001, 16'hC001};
    @(posedge clk_i);
    ldat <= 16'h8001;
    rdat <= 16'h0002;
    for (int r = 0; r < 4; r++) begin
      reg_wr(DPC_OFS_SETUP, {2'b11, r[1:0], r[1:0], 2'b10});
      check(lout, el[r]);
      check(rout, er[r]);
    end
    reg_wr(DPC_OFS_SETUP, 8'hAA);
    check({lpwr, rpwr}, 2'b10);
    check(lout, 16'h0002);
    check(rout, 16'h0000);
    reg_rd(DPC_OFS_SETUP, 8'hAA);
    reg_wr(DPC_OFS_SETUP, 8'hFE);
    @(posedge clk_i);
    ldat <= 16'h7FFF;
    rdat <= 16'h7FFF;
    repeat (2) @(negedge clk_i);
    check(lout, 16'h7FFF);
    check(rout, 16'h7FFF);
    reg_wr(DPC_OFS_SETUP, 8'hD6);
  endtask

  task automatic test_couple;
    logic [7:0] gl [4] = '{8'h10, 8'hF0, 8'h10, 8'h10};
    logic [7:0] gr [4] = '{8'hF0, 8'hF0, 8'h10, 8'hF0};
    drive_vol(8'h10, 8'hF0);
    for (int c = 0; c < 4; c++) begin
      reg_wr(DPC_OFS_VOL_CTL, {4'h0, c[1:0], c[1:0]});
      check({lmute, rmute}, c[1:0]);
      gains(gl[c], gr[c]);
    end
    @(posedge clk_i);
    drc_l <= 1'b1;
    reg_wr(DPC_OFS_VOL_CTL, 8'h01);
    gains(8'h10, 8'hF0);
    @(posedge clk_i);
    drc_l <= 1'b0;
    drc_r <= 1'b1;
    reg_wr(DPC_OFS_VOL_CTL, 8'h02);
    gains(8'h10, 8'hF0);
    @(posedge clk_i);
    drc_r <= 1'b0;
    reg_wr(DPC_OFS_VOL_CTL, 8'h00);
    drive_vol(8'h40, 8'h80);
    gains(DPC_VOL_MAX, DPC_VOL_MIN);
  endtask

  // Ramp targets straddle zero so the signed direction is exercised
  task automatic test_ramp;
    drive_vol(8'h00, 8'h00);
    reg_wr(DPC_OFS_SETUP, 8'hD4);
    drive_vol(8'h03, 8'hFE);
    gains(8'h00, 8'h00);
    pulse(1);
    gains(8'h01, 8'hFF);
    pulse(2);
    gains(8'h03, 8'hFE);
    pulse(1);
    gains(8'h03, 8'hFE);
    reg_wr(DPC_OFS_SETUP, 8'hD5);
    drive_vol(8'h07, 8'hFA);
    pulse(2);
    gains(8'h04, 8'hFD);
    pulse(2);
    gains(8'h05, 8'hFC);
    reg_wr(DPC_OFS_SETUP, 8'hD6);
    gains(8'h07, 8'hFA);
  endtask

  initial begin
    fail_count = 0;
    check_count = 0;
    rst_b_i = 1'b0;
    req = '0;
    din_pin = 1'b0;
    vol_l = 8'h00;
    vol_r = 8'h00;
    drc_l = 1'b0;
    drc_r = 1'b0;
    tick = 1'b0;
    ldat = 16'h0000;
    rdat = 16'h0000;
    test_reset();
    test_din();
    test_prb();
    test_reserved();
    test_route();
    test_couple();
    test_ramp();
    summarize();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
